// ===== verilog/dal_pkg.sv
// Purpose: constants for the debug access layer register set
// Assumes: 8-bit register port, 4-bit offsets from the link layer
// Notes: phy_control_b offset is chosen locally (none printed)
package dal_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [3:0] OFS_PHY_CONTROL_B = 4'h3;
	localparam logic [3:0] OFS_KEY_STATUS = 4'h7;
	localparam logic [3:0] OFS_SYSTEM_RESET_REQUEST = 4'h8;
	localparam logic [3:0] OFS_PORT_CLOCK_CONTROL = 4'h9;
	localparam logic [3:0] OFS_SYSTEM_CONTROL = 4'hA;
	localparam logic [3:0] OFS_SYSTEM_STATUS = 4'hB;
	localparam logic [3:0] OFS_CRC_SCAN_STATUS = 4'hC;
	// ------------------------------------------------------------
	// fields and values
	// ------------------------------------------------------------
	localparam int BIT_SUPPRESS_NACK = 4;
	localparam int BIT_COLLISION_OFF = 3;
	localparam int BIT_PORT_DISABLE = 2;
	localparam int BIT_KEY_UROW = 5;
	localparam int BIT_KEY_PROG = 4;
	localparam int BIT_KEY_ERASE = 3;
	localparam int BIT_RESET_HELD = 0;
	localparam int BIT_USER_ROW_DONE = 1;
	localparam int BIT_CLOCK_REQUEST = 0;
	localparam int BIT_RESET_ACTIVE = 5;
	localparam int BIT_SLEEPING = 4;
	localparam int BIT_PROG_READY = 3;
	localparam int BIT_UROW_READY = 2;
	localparam int BIT_LOCKED = 0;
	localparam logic [7:0] RESET_SIGNATURE = 8'h59;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [2:0] PHY_CONTROL_MASK = 3'h7;
	// clock select codes
	typedef enum logic [1:0] {
		DAL_CLK_RSVD = 2'b00,
		DAL_CLK_16M = 2'b01,
		DAL_CLK_8M = 2'b10,
		DAL_CLK_4M = 2'b11
	} dal_clk_sel_t;
	localparam logic [2:0] CRC_OFF = 3'h0;
	localparam logic [2:0] CRC_BUSY = 3'h1;
	localparam logic [2:0] CRC_GOOD = 3'h2;
	localparam logic [2:0] CRC_FAIL = 3'h4;
endpackage : dal_pkg

// ===== verilog/dal_regs.sv
// Purpose: access layer control and status registers of the debug port
// Assumes: wr/rd strobes are one-cycle pulses synchronous to mclk_i
// Notes: all outputs come from flip-flops; system reset is separate
//
// Behaviour
// - suppress-nack bit stops nack on reset
// - collision detect on unless bit set or port off
// - port disable clears phy, keys, clock request
// - key status shows three key bits
// - programming key clears when programming done
// - erase key clears when erase done
// - 0x59 asserts system reset, else releases
// - reset register reads held reset in bit0
// - system reset never resets this port
// - clock select 1/2/3 gives 16/8/4 MHz
// - user-row-done write starts flash programming
// - user-row-done writable only with key active
// - clock request bit drives clock request
// - clock request set on enable, cleared off
// - reset-active sticky, cleared on read
// - sleep bit follows system sleep state
// - programming ready bit shown when allowed
// - user row ready bit shown when allowed
// - lock bit follows device lock state
// - crc status reports one-hot codes
module dal_regs
	import dal_pkg::*;
(
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic port_enable_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic key_urow_set_i,
	input wire logic key_prog_set_i,
	input wire logic key_erase_set_i,
	input wire logic prog_done_i,
	input wire logic erase_done_i,
	input wire logic sys_in_reset_i,
	input wire logic sys_sleeping_i,
	input wire logic prog_ready_i,
	input wire logic urow_ready_i,
	input wire logic device_locked_i,
	input wire logic [2:0] crc_status_i,
	output logic [7:0] reg_rdata_o,
	output logic suppress_negative_ack_o,
	output logic collision_detect_on_o,
	output logic phy_shutdown_o,
	output logic system_reset_o,
	output logic [1:0] port_clock_select_o,
	output logic system_clock_request_o,
	output logic user_row_done_o
);
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic [2:0] phy_ctl;
	logic [2:0] keys;
	logic reset_held;
	logic [1:0] clk_sel;
	logic clk_req;
	logic rst_active;
	logic en_q;
	logic port_dead;
	logic urow_pulse;
	logic [7:0] next_rdata;
	wire wr_phy = reg_wr_i && reg_addr_i == OFS_PHY_CONTROL_B;
	wire wr_rst = reg_wr_i && reg_addr_i == OFS_SYSTEM_RESET_REQUEST;
	wire wr_clk = reg_wr_i && reg_addr_i == OFS_PORT_CLOCK_CONTROL;
	wire wr_sys = reg_wr_i && reg_addr_i == OFS_SYSTEM_CONTROL;
	wire rd_stat = reg_rd_i && reg_addr_i == OFS_SYSTEM_STATUS;
	// disable write kills the port in the same cycle
	wire disable_now = wr_phy && reg_wdata_i[BIT_PORT_DISABLE];
	wire enable_rise = port_enable_i && !en_q;
	// a one-cycle shutdown would let the link carry on with cleared keys;
	// limitation: only a fresh enable edge brings the port back
	wire port_off = disable_now || !port_enable_i
		|| (port_dead && !enable_rise);
	// key gate: the done bit is dead without the row key
	wire urow_wr = wr_sys && keys[2] && !port_off;
	// clock select field in package bit order (2 lsb of byte)
	wire [1:0] clk_new = reg_wdata_i[1:0];

	// ------------------------------------------------------------
	// phy control, keys, reset request, clock select
	// ------------------------------------------------------------
	// system reset is an output only; this logic sees only arst_n_i
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			phy_ctl <= 3'h0;
			keys <= 3'h0;
			reset_held <= 1'b0;
			clk_sel <= DAL_CLK_4M;
			en_q <= 1'b0;
			port_dead <= 1'b0;
		end else begin
			en_q <= port_enable_i;
			// disable stays in force until the next enable edge
			if (disable_now)
				port_dead <= 1'b1;
			else if (enable_rise)
				port_dead <= 1'b0;
			if (port_off) begin
				phy_ctl <= 3'h0;
				keys <= 3'h0;
				clk_sel <= DAL_CLK_4M;
			end else begin
				if (wr_phy)
					phy_ctl <= reg_wdata_i[4:2] & PHY_CONTROL_MASK;
				// set wins over the completion clear
				keys[2] <= keys[2] || key_urow_set_i;
				keys[1] <= key_prog_set_i || (keys[1] && !prog_done_i);
				keys[0] <= key_erase_set_i || (keys[0] && !erase_done_i);
				if (enable_rise)
					clk_sel <= DAL_CLK_4M;
				else if (wr_clk && clk_new != DAL_CLK_RSVD)
					clk_sel <= clk_new;
			end
			if (wr_rst)
				reset_held <= (reg_wdata_i == RESET_SIGNATURE);
		end
	end

	// ------------------------------------------------------------
	// system control: clock request and user row done
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			clk_req <= 1'b0;
			urow_pulse <= 1'b0;
		end else begin
			urow_pulse <= urow_wr && reg_wdata_i[BIT_USER_ROW_DONE];
			if (port_off)
				clk_req <= 1'b0;
			else if (enable_rise)
				clk_req <= 1'b1;
			else if (wr_sys)
				clk_req <= reg_wdata_i[BIT_CLOCK_REQUEST];
		end
	end

	// ------------------------------------------------------------
	// sticky reset-active flag, set wins over read clear
	// ------------------------------------------------------------
	wire rst_seen = sys_in_reset_i || reset_held;
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			rst_active <= 1'b0;
		else
			rst_active <= rst_seen || (rst_active && !rd_stat);
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always_comb begin
		next_rdata = ZERO_BYTE;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				OFS_PHY_CONTROL_B: next_rdata[4:2] = phy_ctl;
				OFS_KEY_STATUS: next_rdata[5:3] = keys;
				OFS_SYSTEM_RESET_REQUEST:
					next_rdata[BIT_RESET_HELD] = reset_held;
				OFS_PORT_CLOCK_CONTROL: next_rdata[1:0] = clk_sel;
				OFS_SYSTEM_CONTROL: next_rdata[BIT_CLOCK_REQUEST] = clk_req;
				OFS_SYSTEM_STATUS: begin
					next_rdata[BIT_RESET_ACTIVE] = rst_active;
					next_rdata[BIT_SLEEPING] = sys_sleeping_i;
					next_rdata[BIT_PROG_READY] = prog_ready_i;
					next_rdata[BIT_UROW_READY] = urow_ready_i;
					next_rdata[BIT_LOCKED] = device_locked_i;
				end
				OFS_CRC_SCAN_STATUS: next_rdata[2:0] = crc_status_i;
				default: next_rdata = ZERO_BYTE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o <= ZERO_BYTE;
			suppress_negative_ack_o <= 1'b0;
			collision_detect_on_o <= 1'b0;
			phy_shutdown_o <= 1'b1;
			system_reset_o <= 1'b0;
			port_clock_select_o <= DAL_CLK_4M;
			system_clock_request_o <= 1'b0;
			user_row_done_o <= 1'b0;
		end else begin
			reg_rdata_o <= next_rdata;
			suppress_negative_ack_o <= phy_ctl[2];
			collision_detect_on_o <= !phy_ctl[1] && !port_off;
			phy_shutdown_o <= port_off;
			system_reset_o <= reset_held;
			port_clock_select_o <= clk_sel;
			system_clock_request_o <= clk_req && !port_off;
			user_row_done_o <= urow_pulse;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// controls show two edges after a write, a port disable one edge after; read data one edge after
	a_sig_reset: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		wr_rst && reg_wdata_i == RESET_SIGNATURE |-> ##2 system_reset_o)
		else $error("signature did not assert system reset");
	a_other_release: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		wr_rst && reg_wdata_i != RESET_SIGNATURE |-> ##2 !system_reset_o)
		else $error("other value did not release reset");
	a_held_read: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		reg_rd_i && reg_addr_i == OFS_SYSTEM_RESET_REQUEST
		|=> reg_rdata_o == {7'h00, $past(reset_held)})
		else $error("reset request read wrong");
	a_no_port_reset: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		system_reset_o && !port_off && !reg_wr_i && !enable_rise
		|=> clk_sel == $past(clk_sel) && clk_req == $past(clk_req))
		else $error("system reset disturbed the port");
	a_disable_clears: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		disable_now |=> keys == 3'h0 && !clk_req ##0 phy_shutdown_o)
		else $error("disable left keys or clock request");
	a_off_holds: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		port_off |=> phy_shutdown_o && !system_clock_request_o
		&& !collision_detect_on_o)
		else $error("port off but link still active");
	a_snack_set: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		wr_phy && !port_off && reg_wdata_i[BIT_SUPPRESS_NACK]
		|-> ##2 suppress_negative_ack_o)
		else $error("nack suppression not applied");
	a_collision_off: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		wr_phy && !port_off && reg_wdata_i[BIT_COLLISION_OFF]
		|-> ##2 !collision_detect_on_o)
		else $error("collision detect not turned off");
	a_collision_on: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		(wr_phy && !port_off && !reg_wdata_i[BIT_COLLISION_OFF])
		##1 !port_off |=> collision_detect_on_o)
		else $error("collision detect not turned on");
	a_key_read: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		reg_rd_i && reg_addr_i == OFS_KEY_STATUS
		|=> reg_rdata_o == {2'h0, $past(keys), 3'h0})
		else $error("key status read wrong");
	a_prog_clear: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		keys[1] && prog_done_i && !key_prog_set_i |=> !keys[1])
		else $error("programming key not cleared");
	a_erase_clear: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		keys[0] && erase_done_i && !key_erase_set_i |=> !keys[0])
		else $error("erase key not cleared");
	a_clk_default: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		enable_rise |-> ##2 port_clock_select_o == DAL_CLK_4M)
		else $error("clock select not default on enable");
	a_clk_write: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		wr_clk && !port_off && !enable_rise && clk_new != DAL_CLK_RSVD
		|-> ##2 port_clock_select_o == $past(clk_new, 2))
		else $error("clock select write not applied");
	a_clk_reserved: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		wr_clk && !port_off && !enable_rise && clk_new == DAL_CLK_RSVD
		|=> clk_sel == $past(clk_sel))
		else $error("reserved clock code was taken");
	a_urow_pulse: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		urow_wr && reg_wdata_i[BIT_USER_ROW_DONE] |-> ##2 user_row_done_o)
		else $error("done write gave no pulse");
	a_urow_gated: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		wr_sys && !keys[2] |-> ##2 !user_row_done_o)
		else $error("done pulse without row key");
	a_system_clock_request_set: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		wr_sys && !port_off && !enable_rise && reg_wdata_i[BIT_CLOCK_REQUEST]
		|=> clk_req)
		else $error("clock request write not applied");
	a_system_clock_request_out: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		clk_req && !port_off |=> system_clock_request_o)
		else $error("clock request not driven");
	a_system_clock_request_enable: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		enable_rise && !disable_now |=> clk_req)
		else $error("clock request not set on enable");
	a_rst_sticky: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		rst_seen |=> rst_active)
		else $error("reset-active flag missed");
	a_rst_clear: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		rd_stat && !rst_seen |=> !rst_active)
		else $error("reset-active flag not cleared by read");
	a_status_read: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		rd_stat |=> reg_rdata_o[BIT_SLEEPING] == $past(sys_sleeping_i)
		&& reg_rdata_o[BIT_PROG_READY] == $past(prog_ready_i)
		&& reg_rdata_o[BIT_UROW_READY] == $past(urow_ready_i)
		&& reg_rdata_o[BIT_LOCKED] == $past(device_locked_i))
		else $error("system status read wrong");
	a_crc_read: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		reg_rd_i && reg_addr_i == OFS_CRC_SCAN_STATUS
		|=> reg_rdata_o == {5'h00, $past(crc_status_i)})
		else $error("crc status read wrong");
	a_idle_zero: assert property (
		@(posedge mclk_i) disable iff (!arst_n_i)
		!reg_rd_i |=> reg_rdata_o == ZERO_BYTE)
		else $error("read data not zero when idle");
	c_sig_reset: cover property (@(posedge mclk_i) system_reset_o);
	c_urow_done: cover property (@(posedge mclk_i) user_row_done_o);
	c_disable: cover property (@(posedge mclk_i) disable_now);
	c_prog_clear: cover property (@(posedge mclk_i) keys[1] && prog_done_i);
	c_rst_read: cover property (@(posedge mclk_i) rd_stat && rst_active);
endmodule : dal_regs

// ===== sim/dal_debugger.sv
// Purpose: debugger-side model issuing access layer register requests
// Assumes: requests launch on the falling edge, one byte each
// Notes: flash and ram traffic are not modelled
module dal_debugger
	import dal_pkg::*;
(
	input wire logic mclk_i,
	input wire logic [7:0] rdata_i,
	output logic wr_o,
	output logic rd_o,
	output logic [3:0] addr_o,
	output logic [7:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// --------------------------------------------------------------
	// request tasks
	// --------------------------------------------------------------
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 4'h0;
		wdata_o = 8'h00;
	end
	// strobe held across the taking edge, dropped one edge later
	task automatic put(input logic [3:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge mclk_i);
		wr_o = 1'b0;
	endtask : put
	// read data is registered, so take it one edge after the request
	task automatic get(input logic [3:0] a, output logic [7:0] d);
		@(negedge mclk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge mclk_i);
		rd_o = 1'b0;
		d = rdata_i;
	endtask : get
	// fast clocks only with brown-out at its top level
	task automatic pick_clock(input dal_clk_sel_t s, input logic bod_max);
		put(OFS_PORT_CLOCK_CONTROL, {6'h00, bod_max ? s : DAL_CLK_4M});
	endtask : pick_clock
	// row data assumed already in ram before the done bit
	task automatic finish_row;
		put(OFS_SYSTEM_CONTROL, 8'h03);
	endtask : finish_row
	// programming ends with a system reset request
	task automatic end_program;
		put(OFS_SYSTEM_RESET_REQUEST, RESET_SIGNATURE);
	endtask : end_program
endmodule : dal_debugger

// ===== sim/testbench.sv
// Purpose: self-checking bench for the access layer register set
// Assumes: dal_debugger issues every register request
// Notes: system-side levels and pulses come from this bench
module testbench
	import dal_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic en = 1'b1;
	logic [4:0] evt = 5'h00; // keys urow/prog/erase, prog/erase done
	logic [4:0] lvl = 5'h01; // in reset, sleep, prog rdy, row rdy, lock
	logic [2:0] crc = 3'h0;
	logic wr, rd, shut, srst, req, urd, snack, ccon;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, v;
	logic [1:0] csel;
	int num_errors = 0;
	int check_count = 0;
	int cyc = 0;
	initial forever #5 mclk_i = ~mclk_i;
	dal_debugger u_host (.mclk_i(mclk_i), .rdata_i(rdata), .wr_o(wr),
		.rd_o(rd), .addr_o(addr), .wdata_o(wdata));
	dal_regs u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
		.port_enable_i(en), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .key_urow_set_i(evt[4]),
		.key_prog_set_i(evt[3]), .key_erase_set_i(evt[2]),
		.prog_done_i(evt[1]), .erase_done_i(evt[0]),
		.sys_in_reset_i(lvl[4]), .sys_sleeping_i(lvl[3]),
		.prog_ready_i(lvl[2]), .urow_ready_i(lvl[1]),
		.device_locked_i(lvl[0]), .crc_status_i(crc),
		.reg_rdata_o(rdata), .suppress_negative_ack_o(snack),
		.collision_detect_on_o(ccon), .phy_shutdown_o(shut),
		.system_reset_o(srst), .port_clock_select_o(csel),
		.system_clock_request_o(req), .user_row_done_o(urd));
	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] s, e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		u_host.get(a, v);
		chk($sformatf("read of %h", a), v, e);
	endtask : rchk
	task automatic pulse(input logic [4:0] m);
		@(negedge mclk_i) evt = m;
		@(negedge mclk_i) evt = 5'h00;
	endtask : pulse
	// controls land two edges after the write
	task automatic settle;
		repeat (2) @(negedge mclk_i);
	endtask : settle
	task automatic row_done(input logic [7:0] e);
		int n = 0;
		u_host.finish_row();
		repeat (5) @(negedge mclk_i) n += urd;
		chk("user row done pulses", 8'(n), e);
	endtask : row_done
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish
	// hang guard, far above the roughly 150 cycles needed
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic t_reset;
		logic [3:0] ra [7] = '{4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hF};
		logic [7:0] re [7] = '{8'h00, 8'h00, 8'h03, 8'h01, 8'h01, 8'h00, 8'h00};
		for (int i = 0; i < 7; i++) rchk(ra[i], re[i]);
	endtask : t_reset
	task automatic t_reset_req;
		u_host.end_program();
		settle();
		chk("system reset", 8'(srst), 8'h01);
		rchk(OFS_SYSTEM_RESET_REQUEST, 8'h01);
		rchk(OFS_PORT_CLOCK_CONTROL, 8'h03);
		u_host.put(OFS_SYSTEM_RESET_REQUEST, 8'h58);
		settle();
		chk("system reset", 8'(srst), 8'h00);
		rchk(OFS_SYSTEM_RESET_REQUEST, 8'h00);
		// first the flag left by the held reset, then a system-side one
		rchk(OFS_SYSTEM_STATUS, 8'h21);
		rchk(OFS_SYSTEM_STATUS, 8'h01);
		lvl[4] = 1'b1;
		@(negedge mclk_i) lvl[4] = 1'b0;
		rchk(OFS_SYSTEM_STATUS, 8'h21);
		rchk(OFS_SYSTEM_STATUS, 8'h01);
	endtask : t_reset_req
	task automatic t_status;
		logic [4:0] lv [5] = '{5'h08, 5'h04, 5'h02, 5'h01, 5'h00};
		logic [2:0] cc [4] = '{CRC_OFF, CRC_BUSY, CRC_GOOD, CRC_FAIL};
		logic [7:0] ex;
		foreach (lv[i]) begin
			lvl = lv[i];
			ex = {2'h0, lv[i][4:1], 1'b0, lv[i][0]};
			rchk(OFS_SYSTEM_STATUS, ex);
		end
		foreach (cc[i]) begin
			crc = cc[i];
			rchk(OFS_CRC_SCAN_STATUS, {5'h00, cc[i]});
		end
	endtask : t_status
	task automatic t_keys;
		row_done(8'h00);
		pulse(5'h1C);
		rchk(OFS_KEY_STATUS, 8'h38);
		pulse(5'h02);
		rchk(OFS_KEY_STATUS, 8'h28);
		pulse(5'h01);
		rchk(OFS_KEY_STATUS, 8'h20);
		row_done(8'h01);
	endtask : t_keys
	task automatic t_clock;
		for (int i = 1; i < 4; i++) begin
			u_host.pick_clock(dal_clk_sel_t'(i), 1'b1);
			settle();
			chk("clock select", 8'(csel), 8'(i));
		end
		u_host.put(OFS_PORT_CLOCK_CONTROL, 8'hFD);
		rchk(OFS_PORT_CLOCK_CONTROL, 8'h01);
		u_host.put(OFS_PORT_CLOCK_CONTROL, 8'h00);
		settle();
		chk("clock select", 8'(csel), 8'h01);
	endtask : t_clock
	task automatic t_phy;
		u_host.put(OFS_PHY_CONTROL_B, 8'hF0);
		settle();
		chk("suppress nack", 8'(snack), 8'h01);
		chk("collision on", 8'(ccon), 8'h01);
		rchk(OFS_PHY_CONTROL_B, 8'h10);
		u_host.put(OFS_PHY_CONTROL_B, 8'h08);
		u_host.put(OFS_SYSTEM_CONTROL, 8'h00);
		settle();
		chk("suppress nack", 8'(snack), 8'h00);
		chk("collision on", 8'(ccon), 8'h00);
		chk("clock request", 8'(req), 8'h00);
		u_host.put(OFS_SYSTEM_CONTROL, 8'h01);
		pulse(5'h1C);
		u_host.put(OFS_PHY_CONTROL_B, 8'h04);
		settle();
		chk("shutdown", 8'(shut), 8'h01);
		chk("clock request", 8'(req), 8'h00);
		chk("collision on", 8'(ccon), 8'h00);
		rchk(OFS_KEY_STATUS, 8'h00);
		en = 1'b0;
		settle();
		chk("clock request", 8'(req), 8'h00);
		en = 1'b1;
		settle();
		chk("clock request", 8'(req), 8'h01);
		chk("clock select", 8'(csel), 8'h03);
		chk("shutdown", 8'(shut), 8'h00);
	endtask : t_phy
	initial begin
		repeat (16) @(negedge mclk_i);
		arst_n_i = 1'b1;
		settle();
		t_reset();
		t_reset_req();
		t_status();
		t_keys();
		t_clock();
		t_phy();
		tally_and_finish();
	end
endmodule : testbench
